// File: verilog/adc_port_pkg.sv
// Constants and types shared by the serial control port and its helpers.
// Assumes an eight-bit register space behind a 16-bit instruction.
package adc_port_pkg;

  // ----------------------------------------
  // Instruction layout
  // ----------------------------------------
  localparam int RW_BIT       = 15;
  localparam int LEN_HIGH_BIT = 14;
  localparam int LEN_LOW_BIT  = 13;
  localparam int ADDR_BITS    = 13;
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [3:0] BYTE_LAST  = 4'h7;

  typedef enum logic [1:0] {
    LEN_ONE    = 2'b00,
    LEN_TWO    = 2'b01,
    LEN_THREE  = 2'b10,
    LEN_STREAM = 2'b11
  } length_type;

  typedef enum logic {
    PHASE_INSTR = 1'b0,
    PHASE_DATA  = 1'b1
  } phase_type;

  // ----------------------------------------
  // Register space
  // ----------------------------------------
  localparam int REG_COUNT      = 16;
  localparam int REG_INDEX_BITS = 4;
  localparam logic [12:0] REG_LIMIT     = 13'h0010;
  localparam logic [12:0] CONFIG_ADDR   = 13'h0000;
  localparam logic [12:0] ID_ADDR       = 13'h0001;
  localparam logic [12:0] PATTERN_ADDR  = 13'h000D;
  localparam logic [12:0] TRANSFER_ADDR = 13'h00FF;
  localparam int LSB_FIRST_BIT = 6;
  localparam int TRANSFER_BIT  = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Identification value is arbitrary.
  localparam logic [7:0] ID_CODE = 8'h5A;

  // ----------------------------------------
  // Output patterns and timing
  // ----------------------------------------
  localparam logic [11:0] STRAP_WORD   = 12'h800;
  localparam logic [11:0] CHECKER_A    = 12'hAAA;
  localparam logic [11:0] CHECKER_B    = 12'h555;
  localparam logic [3:0]  MODE_CHECKER = 4'h4;
  localparam logic [3:0]  MODE_ONE_BIT = 4'hB;
  localparam logic [3:0]  WORD_LAST    = 4'hB;
  localparam logic [3:0]  FRAME_HIGH   = 4'h6;
  localparam logic [2:0]  STRAP_SETTLE = 3'h6;

endpackage

// File: verilog/sync_3ff.sv
// Three-stage synchroniser; a change counts once stages two and three agree.
// Assumes the input is a level from another clock domain or a pin.
`timescale 1ns/1ps
`default_nettype none
module sync_3ff #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] level
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] level;
  } sync_type;

  sync_type state;
  sync_type next_state;
  logic [WIDTH-1:0] agree;

  always_comb begin
    agree = ~(state.stage2 ^ state.stage3);
    next_state = state;
    next_state.stage1 = asyncIn;
    next_state.stage2 = state.stage1;
    next_state.stage3 = state.stage2;
    next_state.level = (state.stage2 & agree) | (state.level & ~agree);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level = state.level;

endmodule
`default_nettype wire

// File: verilog/pattern_serializer.sv
// Serialises four 12-bit channel words with frame and data clocks.
// Assumes samples are stable in the system clock domain.
`timescale 1ns/1ps
`default_nettype none
module pattern_serializer (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic [3:0][11:0] sampleData,
  input  wire logic             forceStrap,
  input  wire logic [3:0]       patternMode,
  output logic      [3:0]       channelOut,
  output logic                  frameClockOut,
  output logic                  dataClockOut
);

  typedef struct packed {
    logic [3:0]       bitIndex;
    logic [3:0][11:0] words;
    logic             alternate;
    logic [3:0]       chanOut;
    logic             frameOut;
    logic             dataOut;
  } ser_type;

  ser_type state;
  ser_type next_state;
  logic [11:0] patternWord;
  logic [3:0][11:0] loadWord;

  // ----------------------------------------
  // Word selection
  // ----------------------------------------
  always_comb begin
    patternWord = state.alternate ? adc_port_pkg::CHECKER_B : adc_port_pkg::CHECKER_A;
    if (forceStrap || patternMode == adc_port_pkg::MODE_ONE_BIT) begin
      patternWord = adc_port_pkg::STRAP_WORD;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : gen_load
      assign loadWord[ch] = (forceStrap || patternMode == adc_port_pkg::MODE_ONE_BIT ||
                             patternMode == adc_port_pkg::MODE_CHECKER) ?
                            patternWord : sampleData[ch];
    end
  endgenerate

  // ----------------------------------------
  // Shifting
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_state.dataOut = !state.dataOut;
    next_state.frameOut = state.bitIndex < adc_port_pkg::FRAME_HIGH;
    next_state.bitIndex = state.bitIndex + 4'h1;
    for (int i = 0; i < 4; i++) begin
      next_state.chanOut[i] = state.words[i][11];
      next_state.words[i] = {state.words[i][10:0], 1'b0};
    end
    if (state.bitIndex == adc_port_pkg::WORD_LAST) begin
      next_state.bitIndex = 4'h0;
      next_state.words = loadWord;
      next_state.alternate = !state.alternate;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign channelOut = state.chanOut;
  assign frameClockOut = state.frameOut;
  assign dataClockOut = state.dataOut;

endmodule
`default_nettype wire

// File: verilog/adc_serial_control_port.sv
// Three-wire serial control port with a power-up pattern strap fallback.
// Assumes the host drives the port clock only while it runs a frame.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_control_port (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             serialClockPatternPin,
  input  wire logic             portSelectN,
  input  wire logic             serialDataDriveModeIn,
  input  wire logic [3:0][11:0] sampleData,
  output logic                  serialDataDriveModeOut,
  output logic                  serialDataDriveModeEnable,
  output logic      [3:0]       channelOut,
  output logic                  frameClockOut,
  output logic                  dataClockOut,
  output logic                  patternStrapActive
);

  typedef logic [adc_port_pkg::REG_COUNT-1:0][7:0] reg_file_type;

  typedef struct packed {
    adc_port_pkg::phase_type  phase;
    logic [3:0]               bitCount;
    logic [15:0]              shift;
    logic                     readMode;
    adc_port_pkg::length_type length;
    logic [1:0]               bytesLeft;
    logic [12:0]              address;
    logic [7:0]               readShift;
    reg_file_type             staged;
    reg_file_type             active;
    logic                     transferToggle;
  } serial_type;

  typedef struct packed {
    logic [2:0] strapCount;
    logic       patternStrap;
    logic       seenToggle;
    logic [3:0] patternMode;
  } system_type;

  serial_type link;
  serial_type eff;
  serial_type next_link;
  system_type sys;
  system_type next_sys;
  logic       frameOpen;
  logic       restart;
  logic       lsbFirst;
  logic [7:0] newByte;
  logic [2:0] syncLevel;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] read_value(input logic [12:0] addr,
                                            input reg_file_type regs);
    logic [7:0] value;
    value = 8'h00;
    if (addr == adc_port_pkg::ID_ADDR) begin
      value = adc_port_pkg::ID_CODE;
    end else if (addr < adc_port_pkg::REG_LIMIT) begin
      value = regs[addr[adc_port_pkg::REG_INDEX_BITS-1:0]];
    end
    return value;
  endfunction

  function automatic logic [15:0] shift_in(input logic lsb, input logic [15:0] word,
                                           input logic bitIn);
    return lsb ? {bitIn, word[15:1]} : {word[14:0], bitIn};
  endfunction

  // ----------------------------------------
  // Frame presence on the port clock
  // ----------------------------------------
  always_ff @(posedge serialClockPatternPin or negedge arst_n or posedge portSelectN) begin
    if (!arst_n) begin
      frameOpen <= 1'b0;
    end else if (portSelectN) begin
      frameOpen <= 1'b0;
    end else begin
      frameOpen <= 1'b1;
    end
  end

  // ----------------------------------------
  // Serial engine
  // ----------------------------------------
  always_comb begin
    lsbFirst = link.staged[adc_port_pkg::CONFIG_ADDR[3:0]][adc_port_pkg::LSB_FIRST_BIT];
    restart = !frameOpen && (link.bitCount[2:0] != 3'h0 ||
              (link.phase == adc_port_pkg::PHASE_DATA &&
               link.length == adc_port_pkg::LEN_STREAM));
    newByte = 8'h00;
    eff = link;
    next_link = link;
    if (!portSelectN) begin
      if (restart) begin
        eff.phase = adc_port_pkg::PHASE_INSTR;
        eff.bitCount = 4'h0;
      end
      next_link = eff;
      next_link.shift = shift_in(lsbFirst, eff.shift, serialDataDriveModeIn);
      next_link.bitCount = eff.bitCount + 4'h1;
      unique case (eff.phase)
        adc_port_pkg::PHASE_INSTR: begin
          if (eff.bitCount == adc_port_pkg::INSTR_LAST) begin
            next_link.phase = adc_port_pkg::PHASE_DATA;
            next_link.bitCount = 4'h0;
            next_link.readMode = next_link.shift[adc_port_pkg::RW_BIT];
            next_link.length = adc_port_pkg::length_type'(
              next_link.shift[adc_port_pkg::LEN_HIGH_BIT:adc_port_pkg::LEN_LOW_BIT]);
            next_link.bytesLeft =
              next_link.shift[adc_port_pkg::LEN_HIGH_BIT:adc_port_pkg::LEN_LOW_BIT];
            next_link.address = next_link.shift[adc_port_pkg::ADDR_BITS-1:0];
            next_link.readShift =
              read_value(next_link.shift[adc_port_pkg::ADDR_BITS-1:0], eff.staged);
          end
        end
        adc_port_pkg::PHASE_DATA: begin
          next_link.readShift = lsbFirst ? {1'b0, eff.readShift[7:1]} :
                                           {eff.readShift[6:0], 1'b0};
          if (eff.bitCount == adc_port_pkg::BYTE_LAST) begin
            next_link.bitCount = 4'h0;
            newByte = lsbFirst ? next_link.shift[15:8] : next_link.shift[7:0];
            if (!eff.readMode) begin
              if (eff.address == adc_port_pkg::TRANSFER_ADDR &&
                  newByte[adc_port_pkg::TRANSFER_BIT]) begin
                next_link.active = eff.staged;
                next_link.transferToggle = !eff.transferToggle;
              end else if (eff.address < adc_port_pkg::REG_LIMIT &&
                           eff.address != adc_port_pkg::ID_ADDR) begin
                next_link.staged[eff.address[adc_port_pkg::REG_INDEX_BITS-1:0]] = newByte;
              end
            end
            next_link.address = lsbFirst ? eff.address + 13'h0001 :
                                           eff.address - 13'h0001;
            next_link.readShift = read_value(next_link.address, next_link.staged);
            if (eff.length != adc_port_pkg::LEN_STREAM) begin
              if (eff.bytesLeft == 2'h0) begin
                next_link.phase = adc_port_pkg::PHASE_INSTR;
              end else begin
                next_link.bytesLeft = eff.bytesLeft - 2'h1;
              end
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge serialClockPatternPin or negedge arst_n) begin
    if (!arst_n) begin
      link <= '0;
    end else begin
      link <= next_link;
    end
  end

  // ----------------------------------------
  // Read data driver on the falling edge
  // ----------------------------------------
  always_ff @(negedge serialClockPatternPin or negedge arst_n or posedge portSelectN) begin
    if (!arst_n) begin
      serialDataDriveModeEnable <= 1'b0;
      serialDataDriveModeOut <= 1'b0;
    end else if (portSelectN) begin
      serialDataDriveModeEnable <= 1'b0;
      serialDataDriveModeOut <= 1'b0;
    end else begin
      serialDataDriveModeEnable <= link.phase == adc_port_pkg::PHASE_DATA &&
                                   link.readMode;
      serialDataDriveModeOut <= lsbFirst ? link.readShift[0] : link.readShift[7];
    end
  end

  // ----------------------------------------
  // System clock side: straps and transfer crossing
  // ----------------------------------------
  sync_3ff #(
    .WIDTH(3)
  ) u_sync (
    .clock  (clock),
    .arst_n (arst_n),
    .asyncIn({serialClockPatternPin, portSelectN, link.transferToggle}),
    .level  (syncLevel)
  );

  always_comb begin
    next_sys = sys;
    if (sys.strapCount != adc_port_pkg::STRAP_SETTLE) begin
      next_sys.strapCount = sys.strapCount + 3'h1;
      if (sys.strapCount == adc_port_pkg::STRAP_SETTLE - 3'h1) begin
        next_sys.patternStrap = syncLevel[2] & syncLevel[1];
      end
    end
    if (syncLevel[0] != sys.seenToggle) begin
      next_sys.seenToggle = syncLevel[0];
      next_sys.patternMode = link.active[adc_port_pkg::PATTERN_ADDR[3:0]][3:0];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sys <= '0;
    end else begin
      sys <= next_sys;
    end
  end

  assign patternStrapActive = sys.patternStrap;

  pattern_serializer u_serializer (
    .clock        (clock),
    .arst_n       (arst_n),
    .sampleData   (sampleData),
    .forceStrap   (sys.patternStrap),
    .patternMode  (sys.patternMode),
    .channelOut   (channelOut),
    .frameClockOut(frameClockOut),
    .dataClockOut (dataClockOut)
  );

endmodule
`default_nettype wire

// File: verif/adc_serial_control_port_asserts.sv
// Checker for the serial control port, watching only the top-level ports.
// Assumes the port clock stands still while the select is high.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_control_port_asserts (
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic       serialClockPatternPin,
  input wire logic       portSelectN,
  input wire logic       serialDataDriveModeEnable,
  input wire logic [3:0] channelOut,
  input wire logic       frameClockOut,
  input wire logic       dataClockOut,
  input wire logic       patternStrapActive
);
  // ----------------------------------------
  // Instruction bits of a fresh frame
  // ----------------------------------------
  // A frame that stops mid-byte within its instruction, or passes the instruction without driving the pin, ends at the select rise; a read keeps its count
  // across pauses, so every later frame goes unchecked rather than misjudged.
  logic [4:0] bitCount;
  logic       sawDrive;
  always_ff @(posedge serialClockPatternPin or posedge portSelectN or negedge arst_n) begin
    if (!arst_n) begin
      bitCount <= 5'h00;
      sawDrive <= 1'b0;
    end else if (portSelectN) begin
      if (bitCount[2:0] != 3'h0 || (bitCount >= 5'h10 && !sawDrive)) begin
        bitCount <= 5'h00;
        sawDrive <= 1'b0;
      end
    end else begin
      if (serialDataDriveModeEnable) begin
        sawDrive <= 1'b1;
      end
      if (bitCount < 5'h10) begin
        bitCount <= bitCount + 5'h01;
      end
    end
  end
  sequence word_high;
    frameClockOut [*6];
  endsequence
  sequence word_low;
    !frameClockOut [*6];
  endsequence
  a_frame_clock_shape: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(frameClockOut) |-> word_high ##1 word_low) else $error("frame clock shape wrong");
  a_data_clock_runs: assert property (@(posedge clock) disable iff (!arst_n)
    $past(arst_n) |-> dataClockOut != $past(dataClockOut)) else $error("data clock stopped");
  a_strap_word_start: assert property (@(posedge clock) disable iff (!arst_n)
    patternStrapActive && $past(patternStrapActive, 24) && $rose(frameClockOut)
    |-> channelOut == 4'hF) else $error("strap word lacks its top bit");
  a_strap_word_rest: assert property (@(posedge clock) disable iff (!arst_n)
    patternStrapActive && $past(patternStrapActive, 24) && !$rose(frameClockOut)
    |-> channelOut == 4'h0) else $error("strap word has extra bits");
  a_strap_kept: assert property (@(posedge clock) disable iff (!arst_n)
    patternStrapActive |=> patternStrapActive) else $error("strap flag dropped");
  a_strap_absent_kept: assert property (@(posedge clock) disable iff (!arst_n)
    !patternStrapActive [*7] |=> !patternStrapActive) else $error("strap flag rose late");
  a_select_releases: assert property (@(posedge clock) disable iff (!arst_n)
    portSelectN |-> !serialDataDriveModeEnable) else $error("data pin driven while idle");
  a_instr_no_drive: assert property (@(posedge serialClockPatternPin) disable iff (!arst_n)
    !portSelectN && bitCount < 5'h10 |-> !serialDataDriveModeEnable)
    else $error("data pin driven during instruction");
endmodule
bind adc_serial_control_port adc_serial_control_port_asserts checker_inst (
  .clock, .arst_n, .serialClockPatternPin, .portSelectN, .serialDataDriveModeEnable,
  .channelOut, .frameClockOut, .dataClockOut, .patternStrapActive
);
`default_nettype wire

// File: verif/spi_host_model.sv
// Host side of the three-wire port: port clock, select and data.
// Assumes the bench resolves the shared data pin from the device's drive enable.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  output logic      portClock,
  output logic      selectN,
  output logic      hostData,
  input  wire logic pinLevel
);
  initial begin
    portClock = 1'b0;
    selectN = 1'b1;
    hostData = 1'b0;
  end
  // The select is always driven, so every frame and stream ends with the select high.
  task automatic select(input logic level);
    #62.5 selectN = level;
  endtask
  // Released data toggles each bit so a stale level never passes for data.
  task automatic shift(input logic [7:0] txByte, input logic [3:0] nBits,
                       input logic drive, input logic lsb, output logic [7:0] rxByte);
    int idx;
    rxByte = 8'h00;
    for (int k = 0; k < nBits; k++) begin
      idx = lsb ? k : 7 - k;
      hostData = drive ? txByte[idx] : ~hostData;
      #62.5 portClock = 1'b1;
      rxByte[idx] = pinLevel;
      #62.5 portClock = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: verif/adc_serial_control_port_test.sv
// Self-checking bench for the serial control port.
// Assumes the host model drives the port pins of the block.
`timescale 1ns/1ps
`default_nettype none
module adc_serial_control_port_test;
  typedef struct packed {
    logic        pause;
    logic        hold;
    logic [1:0]  count;
    logic [15:0] instr;
    logic [23:0] data;
  } row_type;
  localparam row_type READ_ID = '{1'b0, 1'b0, 2'h1, 16'h8001, 24'h00005A};
  localparam row_type ROWS [11] = '{READ_ID,
    '{1'b0, 1'b0, 2'h1, 16'h0002, 24'h0000A5}, '{1'b0, 1'b1, 2'h1, 16'h0002, 24'h000077},
    '{1'b0, 1'b0, 2'h1, 16'h8002, 24'h0000A5}, '{1'b1, 1'b0, 2'h3, 16'h4005, 24'h112233},
    '{1'b0, 1'b0, 2'h3, 16'hC005, 24'h112233}, '{1'b0, 1'b0, 2'h1, 16'h0001, 24'h0000FF},
    READ_ID, '{1'b0, 1'b0, 2'h1, 16'h8020, 24'h000000},
    '{1'b0, 1'b0, 2'h2, 16'h6008, 24'h00C3D4}, '{1'b0, 1'b0, 2'h3, 16'hE008, 24'hC3D400}};
  logic             clock;
  logic             arst_n;
  logic             strapHigh;
  logic [3:0][11:0] sampleData;
  logic             portClock;
  logic             selectN;
  logic             hostData;
  logic             lsbMode;
  logic             dataOut;
  logic             dataEnable;
  logic [3:0]       channelOut;
  logic             frameClockOut;
  logic             dataClockOut;
  logic             patternStrapActive;
  logic [23:0]      readBack;
  logic [7:0]       rxByte;
  int               num_errors;
  int               check_count;
  int               cycleCount = 0;
  wire logic        pinLevel = dataEnable ? dataOut : hostData;
  wire logic        pinClock = strapHigh | portClock;
  spi_host_model host (.portClock(portClock), .selectN(selectN), .hostData(hostData),
                       .pinLevel(pinLevel));
  adc_serial_control_port uut (
    .clock(clock), .arst_n(arst_n), .serialClockPatternPin(pinClock),
    .portSelectN(selectN), .serialDataDriveModeIn(pinLevel), .sampleData(sampleData),
    .serialDataDriveModeOut(dataOut), .serialDataDriveModeEnable(dataEnable),
    .channelOut(channelOut), .frameClockOut(frameClockOut), .dataClockOut(dataClockOut),
    .patternStrapActive(patternStrapActive)
  );
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic finish_test();
    if (num_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [23:0] expected, input logic [23:0] seen);
    check_count++;
    if (expected !== seen) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, expected, seen);
    end
  endtask
  task automatic run_frame(input row_type row);
    logic [7:0] txByte;
    logic [7:0] rx;
    readBack = 24'h000000;
    host.select(row.hold);
    for (int i = 0; i < row.count + 2; i++) begin
      txByte = (i < 2) ? row.instr[(lsbMode ? i : 1 - i) * 8 +: 8]
                       : row.data[(row.count + 1 - i) * 8 +: 8];
      host.shift(txByte, 4'h8, i < 2 || !row.instr[15], lsbMode, rx);
      if (i >= 2) begin
        readBack = {readBack[15:0], rx};
      end
      if (row.pause && i < row.count + 1) begin
        host.select(1'b1);
        host.select(1'b0);
      end
    end
    host.select(1'b1);
    if (row.instr[15]) begin
      check("read data", row.data, readBack);
    end
  endtask
  task automatic count_pattern(input int expected);
    int hits;
    int toggles;
    logic lastClock;
    hits = 0;
    toggles = 0;
    repeat (24) @(negedge clock);
    lastClock = dataClockOut;
    repeat (24) begin
      @(negedge clock);
      if (channelOut === 4'hF) begin
        hits++;
      end
      if (dataClockOut !== lastClock) begin
        toggles++;
      end
      lastClock = dataClockOut;
    end
    check("pattern bits", 24'(expected), 24'(hits));
    check("data clock toggles", 24'h000018, 24'(toggles));
  endtask
  task automatic do_reset(input logic strap, input logic sel);
    host.select(sel);
    @(negedge clock);
    arst_n = 1'b0;
    strapHigh = strap;
    repeat (6) @(negedge clock);
    arst_n = 1'b1;
    repeat (30) @(negedge clock);
    check("strap flag", {23'h000000, strap & sel}, {23'h000000, patternStrapActive});
    count_pattern((strap & sel) ? 2 : 0);
    strapHigh = 1'b0;
    host.select(1'b1);
  endtask
  // ----------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 4000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    arst_n = 1'b0;
    strapHigh = 1'b0;
    sampleData = {4{12'h000}};
    lsbMode = 1'b0;
    num_errors = 0;
    check_count = 0;
    do_reset(1'b1, 1'b1);
    do_reset(1'b1, 1'b0);
    do_reset(1'b0, 1'b1);
    sampleData = {4{12'hC00}};
    count_pattern(4);
    sampleData = {4{12'h000}};
    foreach (ROWS[r]) begin
      run_frame(ROWS[r]);
    end
    host.select(1'b0);
    host.shift(8'hC3, 4'h4, 1'b1, 1'b0, rxByte);
    host.select(1'b1);
    run_frame(READ_ID);
    run_frame('{1'b0, 1'b0, 2'h1, 16'h0000, 24'h000040});
    lsbMode = 1'b1;
    run_frame(READ_ID);
    run_frame('{1'b0, 1'b0, 2'h1, 16'h0000, 24'h000000});
    lsbMode = 1'b0;
    run_frame(READ_ID);
    run_frame('{1'b0, 1'b0, 2'h1, 16'h000D, 24'h00000B});
    count_pattern(0);
    run_frame('{1'b0, 1'b0, 2'h1, 16'h00FF, 24'h000001});
    count_pattern(2);
    finish_test();
  end
endmodule
`default_nettype wire
